// ### irq_status.sv
// interrupt status collector, lower bits 24..0, with mask and one interrupt line
// assumes sources are on ref_clk except the gpio pins, which are synchronised here
//
// Operation
// - bit 24 latches receive low power idle pulse
// - bit 24 held zero while eee disabled
// - 8 ms watchdog sets bit 23
// - watchdog expiry releases mac reset immediately
// - bit 22 set on write to full fifo
// - receive data dropped while overflow flagged
// - bit 21 set on transmitter error
// - bit 20 stays while usb events pending
// - bit 19 stays while tx disable indicated
// - bit 18 stays while rx disable indicated
// - bit 17 stays while phy interrupt pending
// - bit 16 latches data port completion pulse
// - bit 15 stays while mac errors pending
// - bit 12 read-only usb frame pending
// - bits 11..0 gpio flags, reset follows pins
// - clearing gpio flag clears its wake event
// - status register at offset 00ch, 32 bits
//
// The register addresses and the Wishbone register port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none

module irq_status
    import irq_status_pkg::*;
#(
    parameter int WDOG_LEN = WDOG_CYCLES
) (
    input  wire logic                   ref_clk,
    input  wire logic                   rst_b,
    input  wire logic                   wb_cyc_i,
    input  wire logic                   wb_stb_i,
    input  wire logic                   wb_we_i,
    input  wire logic [11:0]            wb_adr_i,
    input  wire logic [3:0]             wb_sel_i,
    input  wire logic [31:0]            wb_dat_i,
    output logic      [31:0]            wb_dat_o,
    output logic                        wb_ack_o,
    input  wire irq_status_pkg::src_s   src,
    input  wire logic [GPIO_COUNT-1:0]  gpio_pin,
    output logic      [GPIO_COUNT-1:0]  gpio_wake_clear,
    output logic                        rx_data_keep,
    output logic                        mac_reset_release,
    output logic                        irq
);
    import irq_status_pkg::*;

    logic [31:0]            status_q;
    logic [31:0]            status_d;
    logic [31:0]            mask_q;
    logic [1:0]             ctrl_q;
    logic                   wb_ack_q;
    logic [31:0]            rdata_q;
    logic [GPIO_COUNT-1:0]  gp_s1_q;
    logic [GPIO_COUNT-1:0]  gp_s2_q;
    logic [GPIO_COUNT-1:0]  gp_s3_q;
    logic [GPIO_COUNT-1:0]  gp_lvl_q;
    logic [GPIO_COUNT-1:0]  wake_clr_q;
    logic                   seed_q;
    logic [31:0]            wdog_cnt_q;
    wdog_e                  wd_state_q;
    logic                   wd_expire;
    logic                   mac_rel_q;
    logic                   access;
    logic                   wr_status;
    logic [31:0]            wmask;
    logic [31:0]            clr;
    logic [31:0]            set;
    logic                   overflow_evt;
    logic                   eee_en;

    assign access    = wb_cyc_i && wb_stb_i && !wb_ack_q;
    assign wr_status = access && wb_we_i && (wb_adr_i == INT_STATUS_OFF);
    assign eee_en    = ctrl_q[EEE_EN_BIT];
    assign wmask     = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign clr       = wr_status ? (wb_dat_i & wmask & WC_MASK) : 32'h0000_0000;

    // gpio pins come from outside: three stages, change taken when stages two and three agree
    always_ff @(posedge ref_clk) begin
        gp_s1_q <= gpio_pin;
        gp_s2_q <= gp_s1_q;
        gp_s3_q <= gp_s2_q;
    end

    genvar g;
    generate
        for (g = 0; g < GPIO_COUNT; g++) begin : gpio_filt
            always_ff @(posedge ref_clk) begin
                if (gp_s2_q[g] == gp_s3_q[g]) begin
                    gp_lvl_q[g] <= gp_s3_q[g];
                end
            end
        end
    endgenerate

    // reset value of gpio flags follows the pin, caught after reset release
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            seed_q <= 1'b1;
        end else if (gp_s2_q == gp_s3_q) begin
            seed_q <= 1'b0;
        end
    end

    assign overflow_evt = src.rx_fifo_write && src.rx_fifo_full;

    always_comb begin
        set = 32'h0000_0000;
        set[RX_LPI_BIT]  = src.rx_lpi_pulse;
        set[MAC_RTO_BIT] = wd_expire;
        set[RX_OVF_BIT]  = overflow_evt;
        set[TX_ERR_BIT]  = src.tx_error;
        set[USB_EVT_BIT] = src.usb_event;
        set[TX_DIS_BIT]  = src.tx_fifo_disabled || src.mac_tx_disabled;
        set[RX_DIS_BIT]  = src.rx_fifo_disabled || src.mac_rx_disabled;
        set[PHY_EVT_BIT] = src.phy_event;
        set[DP_DONE_BIT] = src.data_port_done;
        set[MAC_ERR_BIT] = src.mac_error;
        set[GPIO_COUNT-1:0] = gp_lvl_q;
    end

    // set wins over clear so an event in the clearing cycle survives
    always_comb begin
        status_d = ((status_q & ~clr) | set) & WC_MASK;
        if (!eee_en) begin
            status_d[RX_LPI_BIT] = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            status_q <= 32'h0000_0000;
        end else if (seed_q) begin
            status_q <= {20'h00000, gp_s3_q};
        end else begin
            status_q <= status_d;
        end
    end

    // a cleared gpio flag also clears the matching wake event
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            wake_clr_q <= '0;
        end else begin
            wake_clr_q <= clr[GPIO_COUNT-1:0];
        end
    end
    assign gpio_wake_clear = wake_clr_q;

    // overflow flag blocks storage until software clears it
    assign rx_data_keep = !status_q[RX_OVF_BIT] && !overflow_evt;

    // reset watchdog: counts once software sets the run bit, while clocks are missing
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            wd_state_q <= WD_IDLE;
            wdog_cnt_q <= 32'h0000_0000;
            mac_rel_q  <= 1'b0;
        end else begin
            case (wd_state_q)
                WD_IDLE: begin
                    mac_rel_q  <= 1'b0;
                    wdog_cnt_q <= 32'h0000_0000;
                    if (ctrl_q[WDOG_RUN_BIT]) begin
                        wd_state_q <= WD_COUNT;
                    end
                end
                WD_COUNT: begin
                    if (src.phy_rx_clk_ok && src.phy_tx_clk_ok) begin
                        mac_rel_q  <= 1'b1;
                        wd_state_q <= WD_DONE;
                    end else if (wd_expire) begin
                        mac_rel_q  <= 1'b1;
                        wd_state_q <= WD_DONE;
                    end else begin
                        wdog_cnt_q <= wdog_cnt_q + 32'h0000_0001;
                    end
                end
                WD_DONE: begin
                    mac_rel_q <= 1'b1;
                    if (!ctrl_q[WDOG_RUN_BIT]) begin
                        wd_state_q <= WD_IDLE;
                    end
                end
                default: wd_state_q <= WD_IDLE;
            endcase
        end
    end
    assign wd_expire = (wd_state_q == WD_COUNT) && !(src.phy_rx_clk_ok && src.phy_tx_clk_ok)
                       && (wdog_cnt_q == 32'(WDOG_LEN - 1));
    // release is combinational on expiry so the mac needs no phy clock edge
    assign mac_reset_release = mac_rel_q || wd_expire;

    // mask and control registers
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            mask_q <= MASK_RESET;
            ctrl_q <= CTRL_RESET;
        end else if (access && wb_we_i) begin
            for (int b = 0; b < 4; b++) begin
                if (wb_sel_i[b] && wb_adr_i == INT_MASK_OFF) begin
                    mask_q[b*8 +: 8] <= wb_dat_i[b*8 +: 8] & WC_MASK[b*8 +: 8];
                end
            end
            if (wb_sel_i[0] && wb_adr_i == SRC_CTRL_OFF) begin
                ctrl_q <= wb_dat_i[1:0];
            end
        end
    end

    // one-cycle ack, read data registered; unmapped reads return zero
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            wb_ack_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
        end else begin
            wb_ack_q <= access;
            if (access && !wb_we_i) begin
                case (wb_adr_i)
                    INT_STATUS_OFF: begin
                        rdata_q <= status_q;
                        rdata_q[USB_TX_FRAME_WAITING_BIT] <= src.usb_tx_frame_waiting;
                    end
                    INT_MASK_OFF: rdata_q <= mask_q;
                    SRC_CTRL_OFF: rdata_q <= {30'h0, ctrl_q};
                    default:      rdata_q <= 32'h0000_0000;
                endcase
            end
        end
    end
    assign wb_ack_o = wb_ack_q;
    assign wb_dat_o = rdata_q;

    assign irq = |(status_q & mask_q);

    // checks
    lpi_gate_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !eee_en |=> !status_q[RX_LPI_BIT])
        else $error("lpi flag set while eee disabled");
    lpi_set_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (src.rx_lpi_pulse && eee_en && !seed_q) |=> status_q[RX_LPI_BIT])
        else $error("lpi pulse not latched");
    wdog_flag_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wd_expire && !seed_q |=> status_q[MAC_RTO_BIT] && mac_rel_q)
        else $error("watchdog expiry not flagged");
    wdog_rel_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wd_expire |-> mac_reset_release)
        else $error("mac reset not released on expiry");
    ovf_drop_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        status_q[RX_OVF_BIT] |-> !rx_data_keep)
        else $error("data kept during overflow");
    ovf_set_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        overflow_evt && !seed_q |=> status_q[RX_OVF_BIT])
        else $error("overflow not flagged");
    level_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (src.mac_error && !seed_q) |=> status_q[MAC_ERR_BIT])
        else $error("level source lost on clear");
    txdis_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (src.mac_tx_disabled && !seed_q) |=> status_q[TX_DIS_BIT])
        else $error("tx disabled flag missing");
    wake_clr_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (wr_status && wb_dat_i[0] && wb_sel_i[0]) |=> gpio_wake_clear[0])
        else $error("wake clear not issued");
    irq_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (|(status_q & mask_q)) |-> irq)
        else $error("irq not raised");

    // source capture, one edge after the source is seen
    dp_set_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (src.data_port_done && !seed_q) |=> status_q[DP_DONE_BIT])
        else $error("data port flag not set");
    rxdis_fifo_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (src.rx_fifo_disabled && !seed_q) |=> status_q[RX_DIS_BIT])
        else $error("rx fifo disabled flag missing");
    rxdis_mac_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (src.mac_rx_disabled && !seed_q) |=> status_q[RX_DIS_BIT])
        else $error("mac rx disabled flag missing");
    txdis_fifo_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (src.tx_fifo_disabled && !seed_q) |=> status_q[TX_DIS_BIT])
        else $error("tx fifo disabled flag missing");
    txerr_set_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (src.tx_error && !seed_q) |=> status_q[TX_ERR_BIT])
        else $error("transmit error flag missing");
    usb_set_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (src.usb_event && !seed_q) |=> status_q[USB_EVT_BIT])
        else $error("usb event flag missing");
    usb_persist_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (status_q[USB_EVT_BIT] && src.usb_event && !seed_q) |=> status_q[USB_EVT_BIT])
        else $error("usb flag lost while event pending");
    phy_set_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (src.phy_event && !seed_q) |=> status_q[PHY_EVT_BIT])
        else $error("phy event flag missing");
    err_sticky_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (status_q[MAC_ERR_BIT] && !clr[MAC_ERR_BIT] && !seed_q) |=> status_q[MAC_ERR_BIT])
        else $error("mac error flag lost without clear");
    gpio_set_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !seed_q |=> ((status_q[GPIO_COUNT-1:0] & $past(gp_lvl_q)) == $past(gp_lvl_q)))
        else $error("gpio level not flagged");
    gpio_seed_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (seed_q && gp_s2_q == gp_s3_q) |=> status_q[GPIO_COUNT-1:0] == $past(gp_s3_q))
        else $error("gpio reset value not taken from pins");

    // sticky flags hold until a one is written, and set wins a clash
    pulse_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (status_q[DP_DONE_BIT] && !clr[DP_DONE_BIT] && !seed_q) |=> status_q[DP_DONE_BIT])
        else $error("data port flag lost without clear");
    lpi_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (status_q[RX_LPI_BIT] && eee_en && !clr[RX_LPI_BIT] && !seed_q)
        |=> status_q[RX_LPI_BIT])
        else $error("lpi flag lost without clear");
    ovf_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (status_q[RX_OVF_BIT] && !clr[RX_OVF_BIT] && !seed_q) |=> status_q[RX_OVF_BIT])
        else $error("overflow flag lost without clear");
    rto_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (status_q[MAC_RTO_BIT] && !clr[MAC_RTO_BIT] && !seed_q) |=> status_q[MAC_RTO_BIT])
        else $error("timeout flag lost without clear");
    rto_only_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (!wd_expire && !status_q[MAC_RTO_BIT] && !seed_q) |=> !status_q[MAC_RTO_BIT])
        else $error("timeout flag set without expiry");
    wc_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (wr_status && wb_sel_i[2] && wb_dat_i[DP_DONE_BIT] && !src.data_port_done && !seed_q)
        |=> !status_q[DP_DONE_BIT])
        else $error("write one did not clear");
    wz_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (wr_status && !wb_dat_i[DP_DONE_BIT] && status_q[DP_DONE_BIT] && !seed_q)
        |=> status_q[DP_DONE_BIT])
        else $error("write zero cleared a flag");
    set_wins_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (wr_status && wb_sel_i[2] && wb_dat_i[DP_DONE_BIT] && src.data_port_done && !seed_q)
        |=> status_q[DP_DONE_BIT])
        else $error("event lost in clearing cycle");
    lvl_reassert_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (src.phy_event && clr[PHY_EVT_BIT] && !seed_q) |=> status_q[PHY_EVT_BIT])
        else $error("level flag cleared while source active");
    rsvd_zero_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (status_q & ~WC_MASK) == 32'h0000_0000)
        else $error("reserved status bit stored");
    ro_bit_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !status_q[USB_TX_FRAME_WAITING_BIT])
        else $error("read-only bit stored");

    // overflow gate in both directions
    ovf_evt_drop_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        overflow_evt |-> !rx_data_keep)
        else $error("data kept on overflow event");
    keep_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (!status_q[RX_OVF_BIT] && !overflow_evt) |-> rx_data_keep)
        else $error("data dropped without overflow");

    // watchdog and mac reset release
    wdog_arm_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (wd_state_q == WD_IDLE && ctrl_q[WDOG_RUN_BIT])
        |=> (wd_state_q == WD_COUNT && wdog_cnt_q == 32'h0000_0000))
        else $error("watchdog did not arm");
    wdog_len_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (wd_state_q == WD_COUNT && wdog_cnt_q < 32'(WDOG_LEN - 1)) |-> !wd_expire)
        else $error("watchdog expired early");
    rel_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (wd_state_q == WD_DONE) |-> mac_reset_release)
        else $error("mac reset release dropped");
    idle_rel_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (wd_state_q == WD_IDLE && !mac_rel_q) |-> !mac_reset_release)
        else $error("mac reset released while idle");
    clk_rel_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (wd_state_q == WD_COUNT && src.phy_rx_clk_ok && src.phy_tx_clk_ok) |=> mac_rel_q)
        else $error("mac reset not released on clocks");

    // wake clear pulses only follow a status write
    wake_only_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        !wr_status |=> gpio_wake_clear == '0)
        else $error("wake clear without write");
    wake_bits_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (wr_status && wb_sel_i[0] && wb_sel_i[1])
        |=> gpio_wake_clear == $past(wb_dat_i[GPIO_COUNT-1:0]))
        else $error("wake clear bits wrong");

    // bus side of the status register
    ack_resp_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        access |=> wb_ack_o)
        else $error("access not acknowledged");
    ack_pulse_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    rd_status_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (access && !wb_we_i && wb_adr_i == INT_STATUS_OFF)
        |=> (wb_dat_o & WC_MASK) == ($past(status_q) & WC_MASK))
        else $error("status read data wrong");
    rd_rsvd_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (access && !wb_we_i && wb_adr_i == INT_STATUS_OFF)
        |=> (wb_dat_o[31:25] == 7'h00 && wb_dat_o[14:13] == 2'h0))
        else $error("reserved bits read nonzero");
    usb_rd_a: assert property (@(posedge ref_clk) disable iff (!rst_b)
        (access && !wb_we_i && wb_adr_i == INT_STATUS_OFF)
        |=> wb_dat_o[USB_TX_FRAME_WAITING_BIT] == $past(src.usb_tx_frame_waiting))
        else $error("frame waiting bit read wrong");

endmodule : irq_status

`default_nettype wire

// ### irq_status_pkg.sv
// package for the interrupt status block: offsets, bit positions, reset values, counts
// assumes a 32-bit classic wishbone slave port on a 40 MHz clock
package irq_status_pkg;

    // register byte addresses
    localparam logic [11:0] INT_STATUS_OFF  = 12'h00c;
    localparam logic [11:0] INT_MASK_OFF    = 12'h018;
    localparam logic [11:0] SRC_CTRL_OFF    = 12'h01c;

    // bit positions in interrupt_status
    localparam int RX_LPI_BIT    = 24;
    localparam int MAC_RTO_BIT   = 23;
    localparam int RX_OVF_BIT    = 22;
    localparam int TX_ERR_BIT    = 21;
    localparam int USB_EVT_BIT   = 20;
    localparam int TX_DIS_BIT    = 19;
    localparam int RX_DIS_BIT    = 18;
    localparam int PHY_EVT_BIT   = 17;
    localparam int DP_DONE_BIT   = 16;
    localparam int MAC_ERR_BIT   = 15;
    localparam int USB_TX_FRAME_WAITING_BIT    = 12;
    localparam int GPIO_COUNT    = 12;

    // bit positions in the control register
    localparam int EEE_EN_BIT    = 0;
    localparam int WDOG_RUN_BIT  = 1;

    // writable-clear bits of interrupt_status (bits 24..15 and 11..0)
    localparam logic [31:0] WC_MASK     = 32'h01ff_8fff;
    localparam logic [31:0] MASK_RESET  = 32'h0000_0000;
    localparam logic [1:0]  CTRL_RESET  = 2'h0;

    // reset watchdog: 8 ms at 40 MHz
    localparam int CLK_HZ        = 40_000_000;
    localparam int WDOG_MS       = 8;
    localparam int WDOG_CYCLES   = (CLK_HZ / 1000) * WDOG_MS;

    // event sources that enter the block
    typedef struct packed {
        logic        rx_lpi_pulse;
        logic        rx_fifo_full;
        logic        rx_fifo_write;
        logic        tx_error;
        logic        usb_event;
        logic        tx_fifo_disabled;
        logic        mac_tx_disabled;
        logic        rx_fifo_disabled;
        logic        mac_rx_disabled;
        logic        phy_event;
        logic        data_port_done;
        logic        mac_error;
        logic        usb_tx_frame_waiting;
        logic        phy_rx_clk_ok;
        logic        phy_tx_clk_ok;
    } src_s;

    typedef enum logic [1:0] {
        WD_IDLE    = 2'b00,
        WD_COUNT   = 2'b01,
        WD_DONE    = 2'b10
    } wdog_e;

endpackage : irq_status_pkg

// ### interrupt_status_lower_bits_test.sv
// testbench for the interrupt status block: wishbone accesses, event sources, mask, watchdog
// assumes irq_status with a shortened watchdog and every source on ref_clk
`timescale 1ns/100ps
`default_nettype none

module interrupt_status_lower_bits_test;
    import irq_status_pkg::*;

    localparam int WLEN = 20;

    logic        ref_clk   = 1'b0;
    logic        rst_b     = 1'b0;
    logic        cyc       = 1'b0;
    logic        stb       = 1'b0;
    logic        we        = 1'b0;
    logic [11:0] adr       = 12'h000;
    logic [3:0]  sel       = 4'h0;
    logic [31:0] dat       = 32'h0;
    logic [31:0] rdat;
    logic        ack;
    src_s        src       = '0;
    logic [11:0] gpio_pin  = 12'h0a5;
    logic [11:0] wake_clr;
    logic [11:0] wake_seen = 12'h000;
    logic        rx_data_keep;
    logic        mac_reset_release;
    logic        irq;
    int          bad_count = 0;
    int          n_checks  = 0;
    int          lvl_bit [8] = '{TX_ERR_BIT, USB_EVT_BIT, TX_DIS_BIT, TX_DIS_BIT,
                                 RX_DIS_BIT, RX_DIS_BIT, PHY_EVT_BIT, MAC_ERR_BIT};

    irq_status #(.WDOG_LEN(WLEN)) DUT (
        .ref_clk(ref_clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .src(src), .gpio_pin(gpio_pin), .gpio_wake_clear(wake_clr),
        .rx_data_keep(rx_data_keep), .mac_reset_release(mac_reset_release), .irq(irq)
    );

    always #12.5 ref_clk = ~ref_clk;

    // wake pulses last one cycle, so collect them rather than catch one edge
    always @(posedge ref_clk) if (rst_b) wake_seen <= wake_seen | wake_clr;

    task automatic summarize;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    // entered just after a rising edge; leaves one idle cycle behind it
    task automatic access(input logic w, input logic [11:0] a, input logic [31:0] d,
                          output logic [31:0] r);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= d;
        sel <= 4'hf;
        do begin
            @(posedge ref_clk);
        end while (ack !== 1'b1);
        r = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
        @(posedge ref_clk);
    endtask : access

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        access(1'b1, a, d, r);
    endtask : wr

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        access(1'b0, a, 32'h0, r);
        check(r, exp);
    endtask : rd_chk

    task automatic drive_lvl(input int i, input logic v);
        case (i)
            0: src.tx_error <= v;
            1: src.usb_event <= v;
            2: src.tx_fifo_disabled <= v;
            3: src.mac_tx_disabled <= v;
            4: src.rx_fifo_disabled <= v;
            5: src.mac_rx_disabled <= v;
            6: src.phy_event <= v;
            default: src.mac_error <= v;
        endcase
    endtask : drive_lvl

    task automatic pulse(input logic dp);
        if (dp) src.data_port_done <= 1'b1;
        else src.rx_lpi_pulse <= 1'b1;
        @(posedge ref_clk);
        src.data_port_done <= 1'b0;
        src.rx_lpi_pulse <= 1'b0;
        @(posedge ref_clk);
    endtask : pulse

    initial begin
        int n;
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (5) @(posedge ref_clk);
        rd_chk(INT_STATUS_OFF, 32'h0000_00a5);
        rd_chk(INT_MASK_OFF, MASK_RESET);
        wr(12'h100, 32'hffff_ffff);
        rd_chk(12'h100, 32'h0);
        rd_chk(INT_MASK_OFF, MASK_RESET);
        gpio_pin <= 12'h000;
        repeat (5) @(posedge ref_clk);
        wr(INT_STATUS_OFF, 32'h0000_00a5);
        repeat (3) @(posedge ref_clk);
        check({20'h0, wake_seen}, 32'h0000_00a5);
        rd_chk(INT_STATUS_OFF, 32'h0);
        // reserved and read-only positions ignore a write of ones
        src.usb_tx_frame_waiting <= 1'b1;
        wr(INT_STATUS_OFF, 32'hfe00_7000);
        rd_chk(INT_STATUS_OFF, 32'h0000_1000);
        src.usb_tx_frame_waiting <= 1'b0;
        @(posedge ref_clk);
        rd_chk(INT_STATUS_OFF, 32'h0);
        pulse(1'b0);
        rd_chk(INT_STATUS_OFF, 32'h0);
        wr(SRC_CTRL_OFF, 32'h1);
        pulse(1'b0);
        rd_chk(INT_STATUS_OFF, 32'h0100_0000);
        wr(SRC_CTRL_OFF, 32'h0);
        rd_chk(INT_STATUS_OFF, 32'h0);
        pulse(1'b1);
        rd_chk(INT_STATUS_OFF, 32'h0001_0000);
        wr(INT_STATUS_OFF, 32'h0001_0000);
        rd_chk(INT_STATUS_OFF, 32'h0);
        src.rx_fifo_full  <= 1'b1;
        src.rx_fifo_write <= 1'b1;
        @(posedge ref_clk);
        src.rx_fifo_write <= 1'b0;
        src.rx_fifo_full  <= 1'b0;
        repeat (2) @(posedge ref_clk);
        check(32'(rx_data_keep), 32'h0);
        rd_chk(INT_STATUS_OFF, 32'h0040_0000);
        wr(INT_STATUS_OFF, 32'h0040_0000);
        check(32'(rx_data_keep), 32'h1);
        wr(INT_MASK_OFF, WC_MASK);
        for (int i = 0; i < 8; i++) begin
            drive_lvl(i, 1'b1);
            repeat (2) @(posedge ref_clk);
            // a clear while the source still stands must not stick
            wr(INT_STATUS_OFF, 32'h1 << lvl_bit[i]);
            rd_chk(INT_STATUS_OFF, 32'h1 << lvl_bit[i]);
            check(32'(irq), 32'h1);
            drive_lvl(i, 1'b0);
            @(posedge ref_clk);
            wr(INT_STATUS_OFF, 32'h1 << lvl_bit[i]);
            rd_chk(INT_STATUS_OFF, 32'h0);
            check(32'(irq), 32'h0);
        end
        wr(INT_MASK_OFF, 32'h0);
        src.phy_event <= 1'b1;
        repeat (2) @(posedge ref_clk);
        check(32'(irq), 32'h0);
        wr(INT_MASK_OFF, 32'h1 << PHY_EVT_BIT);
        check(32'(irq), 32'h1);
        src.phy_event <= 1'b0;
        @(posedge ref_clk);
        wr(INT_STATUS_OFF, 32'h1 << PHY_EVT_BIT);
        check(32'(irq), 32'h0);
        // phy clocks stay absent, so only the watchdog can release the mac
        check(32'(mac_reset_release), 32'h0);
        wr(SRC_CTRL_OFF, 32'h2);
        n = 0;
        while (mac_reset_release !== 1'b1 && n < 100) begin
            @(posedge ref_clk);
            n++;
        end
        check(32'(n >= WLEN - 4 && n <= WLEN + 4), 32'h1);
        repeat (2) @(posedge ref_clk);
        rd_chk(INT_STATUS_OFF, 32'h0080_0000);
        // a second reset must take the gpio flags from the pins again
        gpio_pin <= 12'h3c0;
        rst_b    <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rst_b    <= 1'b1;
        repeat (5) @(posedge ref_clk);
        rd_chk(INT_STATUS_OFF, 32'h0000_03c0);
        wr(INT_STATUS_OFF, 32'h0000_03c0);
        rd_chk(INT_STATUS_OFF, 32'h0000_03c0);
        check(32'(mac_reset_release), 32'h0);
        summarize();
    end

    initial begin
        #(25 * 5000);
        bad_count++;
        summarize();
    end
endmodule : interrupt_status_lower_bits_test

`default_nettype wire
